// ### fcp_pkg.sv
// Constants and types shared by the four-channel modulator
package fcp_pkg;
    localparam int NCH = 4;
    localparam int AXI_ADDR_W = 12;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PRESCALE_PAIRING = 8'h60;
    localparam logic [7:0] IDX_SOURCE_POLARITY = 8'h61;
    localparam logic [7:0] IDX_SCALED_DIVISOR = 8'h62;
    localparam logic [7:0] IDX_CHANNEL_ON = 8'h63;
    localparam logic [7:0] IDX_COUNTER0 = 8'h64;
    localparam logic [7:0] IDX_PERIOD0 = 8'h68;
    localparam logic [7:0] IDX_DUTY0 = 8'h6c;
    // Field positions
    localparam int JOIN_THREE_FOUR_BIT = 7;
    localparam int JOIN_ONE_TWO_BIT = 6;
    localparam int CLOCK_A_FIELD_LSB = 4;
    localparam int CLOCK_B_FIELD_LSB = 0;
    localparam int CLOCK_CHOICE_LSB = 4;
    localparam int POLARITY_LSB = 0;
    localparam int CHANNEL_ON_LSB = 0;
    // Reset value and bus response codes
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Result of one counter step
    typedef struct packed {
        logic [15:0] cnt;
        logic out;
        logic load;
    } fcp_step_t;
endpackage

// ### fcp_top.sv
// Four-channel 8/16-bit pulse-width modulator with AXI4-Lite registers
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module fcp_top #(
    parameter int ADDR_W = fcp_pkg::AXI_ADDR_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [3:0] pwm_out,
    output logic [3:0] pwm_oe_n
);
    localparam int NCH = fcp_pkg::NCH;

    // Software registers
    logic [7:0] scaled_clock_divisor_r;
    logic [7:0] channel_clock_prescale_and_pairing_r;
    logic [7:0] channel_clock_source_and_polarity_r;
    logic [7:0] channel_on_register_r;
    logic [7:0] per_buf_r [NCH];
    logic [7:0] dty_buf_r [NCH];
    logic [7:0] per_act_r [NCH];
    logic [7:0] dty_act_r [NCH];
    logic [7:0] channel_counter_r [NCH];
    logic [3:0] wave_r;

    // Prescalers
    logic [6:0] pre_r;
    logic [7:0] s_cnt_r;
    logic s_ph_r;

    // Bus state
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic aw_hold_r, w_hold_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [7:0] wdata_r;
    logic wstrb0_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic [7:0] lat_r [2];
    logic [1:0] lat_v_r;

    // Field views
    wire [1:0] clock_a_divider_field = channel_clock_prescale_and_pairing_r[fcp_pkg::CLOCK_A_FIELD_LSB +: 2];
    wire [2:0] clock_b_divider_field = channel_clock_prescale_and_pairing_r[fcp_pkg::CLOCK_B_FIELD_LSB +: 3];
    wire join_pair_three_four = channel_clock_prescale_and_pairing_r[fcp_pkg::JOIN_THREE_FOUR_BIT];
    wire join_pair_one_two = channel_clock_prescale_and_pairing_r[fcp_pkg::JOIN_ONE_TWO_BIT];
    wire [1:0] join_pair = {join_pair_three_four, join_pair_one_two};
    wire [3:0] channel_clock_choice = channel_clock_source_and_polarity_r[fcp_pkg::CLOCK_CHOICE_LSB +: 4];
    wire [3:0] channel_output_polarity = channel_clock_source_and_polarity_r[fcp_pkg::POLARITY_LSB +: 4];
    wire [3:0] channel_on_bit = channel_on_register_r[fcp_pkg::CHANNEL_ON_LSB +: 4];

    // Low bits of the free counter that must be zero for a divided tick
    function automatic logic [6:0] div_mask(input logic [2:0] f);
        div_mask = 7'h7f >> (3'd7 - f);
    endfunction

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        addr_ok = (a[1:0] == 2'b00) && (a[ADDR_W-1:10] == '0);
    endfunction

    // One count step of an 8-bit channel or a joined 16-bit pair
    function automatic fcp_pkg::fcp_step_t chan_step(
        input logic [15:0] cnt,
        input logic [15:0] per,
        input logic [15:0] dty,
        input logic clr,
        input logic go,
        input logic pol,
        input logic out
    );
        fcp_pkg::fcp_step_t s;
        s.cnt = cnt;
        s.out = out;
        s.load = 1'b0;
        if (clr) begin
            s.cnt = 16'h0000;
            s.load = 1'b1;
        end else if (go) begin
            if (cnt == per) begin
                s.cnt = 16'h0000;
                s.out = pol;
                s.load = 1'b1;
            end else begin
                // Counter never passes the period, so no wrap term is needed
                s.cnt = cnt + 16'h0001;
                if (cnt == dty) begin
                    s.out = ~pol;
                end
            end
        end
        chan_step = s;
    endfunction

    // Scaled clocks
    wire tick_a = (pre_r & div_mask({1'b0, clock_a_divider_field})) == 7'h00;
    wire tick_b = (pre_r & div_mask(clock_b_divider_field)) == 7'h00;
    // Divisor N counts N clock A ticks; zero wraps to a full 256
    wire s_wrap = s_cnt_r == (scaled_clock_divisor_r - 8'h01);
    wire tick_s = tick_a && s_wrap && s_ph_r;

    logic [3:0] tick_ch;
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            if (channel_clock_choice[i]) begin
                tick_ch[i] = tick_s;
            end else if (i >= 2) begin
                tick_ch[i] = tick_b;
            end else begin
                tick_ch[i] = tick_a;
            end
        end
    end

    // Write path
    wire aw_take = s_axi_awvalid && awready_r;
    wire w_take = s_axi_wvalid && wready_r;
    wire wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
    wire [7:0] wr_idx = awaddr_r[9:2];
    wire wr_ok = addr_ok(awaddr_r);
    wire wr_en = wr_fire && wr_ok && wstrb0_r;
    wire wr_pair = wr_en && (wr_idx == fcp_pkg::IDX_PRESCALE_PAIRING);
    wire wr_src = wr_en && (wr_idx == fcp_pkg::IDX_SOURCE_POLARITY);
    wire wr_scal = wr_en && (wr_idx == fcp_pkg::IDX_SCALED_DIVISOR);
    wire wr_on = wr_en && (wr_idx == fcp_pkg::IDX_CHANNEL_ON);
    wire [7:0] wr_cnt_off = wr_idx - fcp_pkg::IDX_COUNTER0;
    wire [7:0] wr_per_off = wr_idx - fcp_pkg::IDX_PERIOD0;
    wire [7:0] wr_dty_off = wr_idx - fcp_pkg::IDX_DUTY0;
    wire wr_cnt = wr_en && (wr_cnt_off < 8'h04);
    wire wr_per = wr_en && (wr_per_off < 8'h04);
    wire wr_dty = wr_en && (wr_dty_off < 8'h04);
    wire [3:0] cnt_clr = wr_cnt ? (4'h1 << wr_cnt_off[1:0]) : 4'h0;
    wire wr_mapped = wr_ok && (wr_idx >= fcp_pkg::IDX_PRESCALE_PAIRING) && (wr_idx <= fcp_pkg::IDX_DUTY0 + 8'h03);
    wire aw_hold_nxt = (aw_hold_r && !wr_fire) || aw_take;
    wire w_hold_nxt = (w_hold_r && !wr_fire) || w_take;
    wire bvalid_nxt = (bvalid_r && !s_axi_bready) || wr_fire;

    // Read path
    wire rd_fire = s_axi_arvalid && arready_r;
    wire [7:0] rd_idx = s_axi_araddr[9:2];
    wire rd_ok = addr_ok(s_axi_araddr);
    wire [7:0] rd_cnt_off = rd_idx - fcp_pkg::IDX_COUNTER0;
    wire [7:0] rd_per_off = rd_idx - fcp_pkg::IDX_PERIOD0;
    wire [7:0] rd_dty_off = rd_idx - fcp_pkg::IDX_DUTY0;
    wire rd_is_cnt = rd_cnt_off < 8'h04;
    wire rd_hi_joined = rd_fire && rd_ok && rd_is_cnt && !rd_cnt_off[0] && join_pair[rd_cnt_off[1]];
    wire rd_lo_latched = rd_is_cnt && rd_cnt_off[0] && join_pair[rd_cnt_off[1]] && lat_v_r[rd_cnt_off[1]];
    wire rvalid_nxt = (rvalid_r && !s_axi_rready) || rd_fire;

    logic [7:0] rd_byte;
    logic rd_hit;
    always_comb begin
        rd_hit = rd_ok;
        rd_byte = 8'h00;
        if (!rd_ok) begin
            rd_hit = 1'b0;
        end else if (rd_idx == fcp_pkg::IDX_PRESCALE_PAIRING) begin
            rd_byte = channel_clock_prescale_and_pairing_r;
        end else if (rd_idx == fcp_pkg::IDX_SOURCE_POLARITY) begin
            rd_byte = channel_clock_source_and_polarity_r;
        end else if (rd_idx == fcp_pkg::IDX_SCALED_DIVISOR) begin
            rd_byte = scaled_clock_divisor_r;
        end else if (rd_idx == fcp_pkg::IDX_CHANNEL_ON) begin
            rd_byte = channel_on_register_r;
        end else if (rd_lo_latched) begin
            rd_byte = lat_r[rd_cnt_off[1]];
        end else if (rd_is_cnt) begin
            rd_byte = channel_counter_r[rd_cnt_off[1:0]];
        end else if (rd_per_off < 8'h04) begin
            rd_byte = per_buf_r[rd_per_off[1:0]];
        end else if (rd_dty_off < 8'h04) begin
            rd_byte = dty_buf_r[rd_dty_off[1:0]];
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Channel stepping
    fcp_pkg::fcp_step_t st [NCH];
    logic [3:0] load_ch;
    logic [7:0] cnt_nxt [NCH];
    logic [3:0] wave_nxt;
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            if (join_pair[p]) begin
                // Low channel owns clock, enable, polarity and the pin
                st[2*p+1] = chan_step({channel_counter_r[2*p], channel_counter_r[2*p+1]},
                    {per_act_r[2*p], per_act_r[2*p+1]}, {dty_act_r[2*p], dty_act_r[2*p+1]},
                    cnt_clr[2*p+1], channel_on_bit[2*p+1] && tick_ch[2*p+1],
                    channel_output_polarity[2*p+1], wave_r[2*p+1]);
                st[2*p] = st[2*p+1];
                st[2*p].out = wave_r[2*p];
                cnt_nxt[2*p] = st[2*p+1].cnt[15:8];
                cnt_nxt[2*p+1] = st[2*p+1].cnt[7:0];
            end else begin
                for (int j = 2*p; j < 2*p+2; j++) begin
                    st[j] = chan_step({8'h00, channel_counter_r[j]}, {8'h00, per_act_r[j]},
                        {8'h00, dty_act_r[j]}, cnt_clr[j], channel_on_bit[j] && tick_ch[j],
                        channel_output_polarity[j], wave_r[j]);
                    cnt_nxt[j] = st[j].cnt[7:0];
                end
            end
        end
        for (int i = 0; i < NCH; i++) begin
            load_ch[i] = st[i].load;
            wave_nxt[i] = st[i].out;
        end
    end

    // Pin drive: off channels and joined high-order pins are released
    wire [3:0] drive = channel_on_bit & ~{1'b0, join_pair_three_four, 1'b0, join_pair_one_two};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_r <= 7'h00;
            s_cnt_r <= 8'h00;
            s_ph_r <= 1'b0;
        end else begin
            pre_r <= pre_r + 7'h01;
            // Restarting on a new divisor avoids a 256-tick detour
            if (wr_scal) begin
                s_cnt_r <= 8'h00;
                s_ph_r <= 1'b0;
            end else if (tick_a) begin
                s_cnt_r <= s_wrap ? 8'h00 : s_cnt_r + 8'h01;
                s_ph_r <= s_ph_r ^ s_wrap;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scaled_clock_divisor_r <= fcp_pkg::REG_RESET;
            channel_clock_prescale_and_pairing_r <= fcp_pkg::REG_RESET;
            channel_clock_source_and_polarity_r <= fcp_pkg::REG_RESET;
            channel_on_register_r <= fcp_pkg::REG_RESET;
        end else begin
            if (wr_scal) scaled_clock_divisor_r <= wdata_r;
            if (wr_pair) channel_clock_prescale_and_pairing_r <= wdata_r;
            if (wr_src) channel_clock_source_and_polarity_r <= wdata_r;
            if (wr_on) channel_on_register_r <= wdata_r;
        end
    end

    always_ff @(posedge aclk) begin
        for (int i = 0; i < NCH; i++) begin
            if (!aresetn) begin
                per_buf_r[i] <= fcp_pkg::REG_RESET;
                dty_buf_r[i] <= fcp_pkg::REG_RESET;
                per_act_r[i] <= fcp_pkg::REG_RESET;
                dty_act_r[i] <= fcp_pkg::REG_RESET;
                channel_counter_r[i] <= fcp_pkg::REG_RESET;
            end else begin
                if (wr_per && wr_per_off[1:0] == i[1:0]) per_buf_r[i] <= wdata_r;
                if (wr_dty && wr_dty_off[1:0] == i[1:0]) dty_buf_r[i] <= wdata_r;
                if (load_ch[i]) begin
                    per_act_r[i] <= per_buf_r[i];
                    dty_act_r[i] <= dty_buf_r[i];
                end
                channel_counter_r[i] <= cnt_nxt[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wave_r <= 4'h0;
            pwm_out <= 4'h0;
            pwm_oe_n <= 4'hf;
        end else begin
            wave_r <= wave_nxt;
            pwm_out <= wave_r & drive;
            pwm_oe_n <= ~drive;
        end
    end

    // Coherent 16-bit counter reads
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lat_v_r <= 2'b00;
            lat_r[0] <= 8'h00;
            lat_r[1] <= 8'h00;
        end else if (rd_fire) begin
            lat_v_r <= 2'b00;
            if (rd_hi_joined) begin
                lat_r[rd_cnt_off[1]] <= channel_counter_r[{rd_cnt_off[1], 1'b1}];
                lat_v_r[rd_cnt_off[1]] <= 1'b1;
            end
        end
    end

    // AXI4-Lite slave
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 8'h00;
            wstrb0_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= fcp_pkg::RESP_OKAY;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            if (aw_take) awaddr_r <= s_axi_awaddr;
            if (w_take) begin
                wdata_r <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
            end
            awready_r <= !aw_hold_nxt && !bvalid_nxt;
            wready_r <= !w_hold_nxt && !bvalid_nxt;
            bvalid_r <= bvalid_nxt;
            if (wr_fire) bresp_r <= wr_mapped ? fcp_pkg::RESP_OKAY : fcp_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= fcp_pkg::RESP_OKAY;
        end else begin
            arready_r <= !rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (rd_fire) begin
                rdata_r <= {24'h00_0000, rd_byte};
                rresp_r <= rd_hit ? fcp_pkg::RESP_OKAY : fcp_pkg::RESP_SLVERR;
            end
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
endmodule // fcp_top

// ### fcp_top_assertions.sv
// Port-level checker for the four-channel modulator
`timescale 1ns/1ps
module fcp_top_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic [3:0] pwm_out,
    input wire logic [3:0] pwm_oe_n
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    a_reset_idle: assert property ($rose(aresetn) |-> pwm_oe_n == 4'hf && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not idle after reset");
    a_write_answer: assert property (aw_hs && w_hs |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after handshake");
    a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    a_read_answer: assert property (ar_hs |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted during response");
    a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_bad_write: assert property (aw_hs && s_axi_awaddr[1:0] != 2'b00
        |-> ##[1:8] (s_axi_bvalid && s_axi_bresp == fcp_pkg::RESP_SLVERR))
        else $error("misaligned write not refused");
    a_bad_read: assert property (ar_hs && s_axi_araddr[11:10] != 2'b00
        |=> s_axi_rvalid && s_axi_rresp == fcp_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_pin_release: assert property ((pwm_oe_n & pwm_out) == 4'h0)
        else $error("released pin shows a level");
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == fcp_pkg::RESP_SLVERR);
    c_pin_drive: cover property (pwm_oe_n != 4'hf);
    c_read_data: cover property (s_axi_rvalid && s_axi_rdata != 32'h0);
endmodule // fcp_top_chk

bind fcp_top fcp_top_chk #(.ADDR_W(ADDR_W)) i_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n)
);

// ### fcp_load.sv
// External loads on the four modulator port pins
`timescale 1ns/1ps
module fcp_load (
    input wire logic aclk,
    input wire logic [3:0] pwm_out,
    input wire logic [3:0] pwm_oe_n,
    output logic [3:0] pin
);
    logic [3:0] last_r = 4'h0;
    always_ff @(posedge aclk) begin
        last_r <= pin;
    end
    // No pull on these pins: a released pin toggles so a stale level is never mistaken for drive
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin[i] = (pwm_oe_n[i] !== 1'b0) ? ~last_r[i] : pwm_out[i];
        end
    end
endmodule // fcp_load

// ### four_channel_pwm_with_prescalers_test.sv
// Self-checking bench for the four-channel modulator
`timescale 1ns/1ps
module four_channel_pwm_with_prescalers_test;
    localparam logic [1:0] OK = fcp_pkg::RESP_OKAY;
    localparam logic [1:0] SE = fcp_pkg::RESP_SLVERR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h0;
    logic [11:0] araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] pwm_out, pwm_oe_n, pin;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #50 aclk = ~aclk;
    fcp_top i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n)
    );
    fcp_load i_load (.aclk(aclk), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .pin(pin));
    task automatic stop_test();
        if (n_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    function automatic logic [11:0] ad(input int i);
        return 12'(i * 4);
    endfunction
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        logic b_done;
        b_done = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!b_done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                b_done = 1'b1;
                chk(32'(bresp), 32'(er));
            end
        end
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
        logic r_done;
        r_done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!r_done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                r_done = 1'b1;
                d = rdata;
                chk(32'(rresp), 32'(er));
            end
        end
    endtask
    // Times one full active phase and one idle phase after a clean edge
    task automatic meas(input int ch, input logic act, input int eh, input int el);
        int h, l;
        h = 0;
        l = 0;
        repeat (4) @(posedge aclk);
        while (pin[ch] === act) @(posedge aclk);
        while (pin[ch] !== act) @(posedge aclk);
        while (pin[ch] === act) begin
            h++;
            @(posedge aclk);
        end
        while (pin[ch] !== act) begin
            l++;
            @(posedge aclk);
        end
        chk(h, eh);
        chk(l, el);
    endtask
    // Period 9, duty 3: active for 6 ticks, idle for 4, tick length dv cycles
    task automatic wave(input int ch, input logic [7:0] ck, input logic [7:0] pl, input logic [7:0] sc, input int dv);
        wr(ad(fcp_pkg::IDX_SCALED_DIVISOR), sc, OK);
        wr(ad(fcp_pkg::IDX_PRESCALE_PAIRING), ck, OK);
        wr(ad(fcp_pkg::IDX_SOURCE_POLARITY), pl, OK);
        wr(ad(fcp_pkg::IDX_PERIOD0 + ch), 8'h09, OK);
        wr(ad(fcp_pkg::IDX_DUTY0 + ch), 8'h03, OK);
        wr(ad(fcp_pkg::IDX_COUNTER0 + ch), 8'h00, OK);
        wr(ad(fcp_pkg::IDX_CHANNEL_ON), 8'(1 << ch), OK);
        meas(ch, ~pl[ch], 6 * dv, 4 * dv);
        chk(32'(pwm_oe_n), 32'(4'(~(4'h1 << ch))));
        wr(ad(fcp_pkg::IDX_CHANNEL_ON), 8'h00, OK);
        repeat (3) @(posedge aclk);
        chk(32'(pwm_oe_n), 32'hf);
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        logic [31:0] d, h, l, h2, l2;
        int c1, c2, v1, v2;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 8'h60; i < 8'h70; i++) begin
            rd(ad(i), d, OK);
            chk(d, 32'h0);
        end
        rd(12'h100, d, SE);
        chk(d, 32'h0);
        rd(12'hc00, d, SE);
        wr(12'h181, 8'h55, SE);
        wr(ad(fcp_pkg::IDX_PRESCALE_PAIRING), 8'h88, OK);
        rd(ad(fcp_pkg::IDX_PRESCALE_PAIRING), d, OK);
        chk(d, 32'h88);
        for (int i = 8'h68; i < 8'h70; i++) begin
            wr(ad(i), 8'(i * 3), OK);
            rd(ad(i), d, OK);
            chk(d, 32'(8'(i * 3)));
        end
        for (int i = 0; i < 4; i++) wave(0, 8'(i << 4), 8'h00, 8'h00, 1 << i);
        for (int i = 0; i < 8; i++) wave(2, 8'(i), 8'(i % 2) << 2, 8'h00, 1 << i);
        wave(1, 8'h10, 8'h20, 8'h02, 8);
        wave(3, 8'h00, 8'h88, 8'h00, 512);
        rd(ad(fcp_pkg::IDX_COUNTER0), h, OK);
        repeat (20) @(posedge aclk);
        rd(ad(fcp_pkg::IDX_COUNTER0), l, OK);
        chk(l, h);
        wr(ad(fcp_pkg::IDX_COUNTER0), 8'hff, OK);
        rd(ad(fcp_pkg::IDX_COUNTER0), d, OK);
        chk(d, 32'h0);
        // Pair one/two joined; high channel on clock S so a wrong clock source shows
        wr(ad(8'h60), 8'h40, OK);
        wr(ad(8'h61), 8'h10, OK);
        wr(ad(8'h68), 8'h01, OK);
        wr(ad(8'h69), 8'h03, OK);
        wr(ad(8'h6c), 8'h00, OK);
        wr(ad(8'h6d), 8'h03, OK);
        wr(ad(8'h65), 8'h00, OK);
        wr(ad(8'h63), 8'h02, OK);
        meas(1, 1'b1, 256, 4);
        chk(32'(pwm_oe_n), 32'hd);
        // Phase steps every 65 pairs so a byte carry falls between some high and low reads
        for (int k = 0; k < 264; k++) begin
            rd(ad(8'h64), h2, OK);
            c2 = cyc;
            rd(ad(8'h65), l2, OK);
            v2 = {h2[7:0], l2[7:0]};
            if (k > 0) chk((v2 + 260 - v1) % 260, (c2 - c1) % 260);
            v1 = v2;
            c1 = c2;
            if (k % 65 == 64) @(posedge aclk);
        end
        wr(ad(8'h63), 8'h00, OK);
        rd(ad(8'h64), h, OK);
        rd(ad(8'h65), l, OK);
        wr(ad(8'h64), 8'h00, OK);
        rd(ad(8'h64), h2, OK);
        rd(ad(8'h65), l2, OK);
        chk({h2[15:0], l2[15:0]}, {h[15:0], l[15:0]});
        wr(ad(8'h65), 8'h00, OK);
        rd(ad(8'h64), h, OK);
        rd(ad(8'h65), l, OK);
        chk({h[15:0], l[15:0]}, 32'h0);
        stop_test();
    end
endmodule // four_channel_pwm_with_prescalers_test
